/* common/sbf_pkg.sv */
// Package: constants, types and encodings of the shift, bit and flag execution unit
package sbf_pkg;

  // ----------------------------------------
  // Register map over AHB-Lite
  // ----------------------------------------
  localparam logic [7:0] SBF_CMD_OFS = 8'h00;
  localparam logic [7:0] SBF_WREG_OFS = 8'h04;
  localparam logic [7:0] SBF_STATUS_OFS = 8'h08;
  localparam logic [7:0] SBF_STATE_OFS = 8'h0C;

  // ----------------------------------------
  // Command word fields
  // ----------------------------------------
  localparam int SBF_OP_LSB = 0;
  localparam int SBF_SEL_LSB = 8;

  // ----------------------------------------
  // Status register bit positions
  // ----------------------------------------
  localparam int SBF_FLAG_C = 0;
  localparam int SBF_FLAG_Z = 1;
  localparam int SBF_FLAG_N = 2;
  localparam int SBF_FLAG_V = 3;
  localparam int SBF_FLAG_S = 4;
  localparam int SBF_FLAG_H = 5;
  localparam int SBF_FLAG_T = 6;
  localparam int SBF_FLAG_I = 7;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] SBF_WREG_RST = 8'h00;
  localparam logic [7:0] SBF_STATUS_RST = 8'h00;
  localparam int SBF_CYC_SINGLE = 1;
  localparam int SBF_CYC_SLEEP = 3;

  typedef enum logic [4:0] {
    SBF_OP_NOP = 5'h00,
    SBF_OP_SHIFT_LEFT_LOGICAL = 5'h01,
    SBF_OP_SHIFT_RIGHT_LOGICAL = 5'h02,
    SBF_OP_ROTATE_LEFT_CARRY = 5'h03,
    SBF_OP_ROTATE_RIGHT_CARRY = 5'h04,
    SBF_OP_SHIFT_RIGHT_ARITH = 5'h05,
    SBF_OP_NIBBLE_SWAP = 5'h06,
    SBF_OP_FLAG_SET_GENERIC = 5'h07,
    SBF_OP_FLAG_CLEAR_GENERIC = 5'h08,
    SBF_OP_BIT_TO_TRANSFER_FLAG = 5'h09,
    SBF_OP_TRANSFER_FLAG_TO_BIT = 5'h0A,
    SBF_OP_SIGN_FLAG_SET = 5'h0B,
    SBF_OP_SIGN_FLAG_CLEAR = 5'h0C,
    SBF_OP_OVERFLOW_FLAG_SET = 5'h0D,
    SBF_OP_OVERFLOW_FLAG_CLEAR = 5'h0E,
    SBF_OP_HALF_CARRY_SET = 5'h0F,
    SBF_OP_HALF_CARRY_CLEAR = 5'h10,
    SBF_OP_INTERRUPT_ENABLE_INSTR = 5'h11,
    SBF_OP_INTERRUPT_DISABLE_INSTR = 5'h12,
    SBF_OP_SLEEP = 5'h13,
    SBF_OP_WATCHDOG_RESTART_INSTR = 5'h14
  } sbf_op_t;

  // Decoded command carried from bus write to execution
  typedef struct packed {
    logic [2:0] sel;
    logic [4:0] op;
  } sbf_cmd_t;

  // AHB-Lite slave request bundle
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } sbf_ahb_req_t;

endpackage

/* rtl/sbf_exec_unit.sv */
// Shift, rotate, bit-transfer and flag execution unit with AHB-Lite register access
`timescale 1ns/1ps
module sbf_exec_unit (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire sbf_pkg::sbf_ahb_req_t ahb_req,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Execution events to neighbouring mechanisms
  output logic sleep_req,
  output logic watchdog_restart,
  output logic busy
);
  import sbf_pkg::*;

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic [7:0] wreg_r;
  logic [7:0] status_r;
  logic [1:0] sleep_cnt_r;
  logic sleep_req_r;
  logic wdr_r;
  logic [31:0] hrdata_r;

  wire addr_ok = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
  wire wr_cmd = wr_pend_r && (addr_r == SBF_CMD_OFS);
  wire wr_wreg = wr_pend_r && (addr_r == SBF_WREG_OFS);
  wire wr_stat = wr_pend_r && (addr_r == SBF_STATUS_OFS);
  // Sleep stalls the bus so no new command lands mid-sleep
  wire sleeping = (sleep_cnt_r != 2'd0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else if (hreadyout) begin
      wr_pend_r <= addr_ok && ahb_req.hwrite;
      rd_pend_r <= addr_ok && !ahb_req.hwrite;
      addr_r <= ahb_req.haddr[7:0];
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  sbf_cmd_t cmd;
  assign cmd.op = hwdata[SBF_OP_LSB +: 5];
  assign cmd.sel = hwdata[SBF_SEL_LSB +: 3];
  wire go = wr_cmd && hreadyout;
  wire [7:0] sel_mask = 8'h01 << cmd.sel;
  wire c_in = status_r[SBF_FLAG_C];
  wire t_in = status_r[SBF_FLAG_T];

  // ----------------------------------------
  // Shift datapath
  // ----------------------------------------
  logic [7:0] res;
  logic c_out;
  logic shift_op;
  logic [7:0] wreg_nxt;
  logic [7:0] status_nxt;

  always_comb begin
    res = wreg_r;
    c_out = c_in;
    shift_op = 1'b1;
    unique case (sbf_op_t'(cmd.op))
      SBF_OP_SHIFT_LEFT_LOGICAL: begin
        res = {wreg_r[6:0], 1'b0};
        c_out = wreg_r[7];
      end
      SBF_OP_SHIFT_RIGHT_LOGICAL: begin
        res = {1'b0, wreg_r[7:1]};
        c_out = wreg_r[0];
      end
      SBF_OP_ROTATE_LEFT_CARRY: begin
        res = {wreg_r[6:0], c_in};
        c_out = wreg_r[7];
      end
      SBF_OP_ROTATE_RIGHT_CARRY: begin
        res = {c_in, wreg_r[7:1]};
        c_out = wreg_r[0];
      end
      SBF_OP_SHIFT_RIGHT_ARITH: begin
        res = {wreg_r[7], wreg_r[7:1]};
        c_out = wreg_r[0];
      end
      default: shift_op = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next working register and flags
  // ----------------------------------------
  always_comb begin
    wreg_nxt = wreg_r;
    status_nxt = status_r;
    if (go) begin
      if (shift_op) begin
        wreg_nxt = res;
        status_nxt[SBF_FLAG_C] = c_out;
        status_nxt[SBF_FLAG_Z] = (res == 8'h00);
        status_nxt[SBF_FLAG_N] = res[7];
        status_nxt[SBF_FLAG_V] = res[7] ^ c_out;
      end else begin
        unique case (sbf_op_t'(cmd.op))
          SBF_OP_NIBBLE_SWAP: wreg_nxt = {wreg_r[3:0], wreg_r[7:4]};
          SBF_OP_FLAG_SET_GENERIC: status_nxt = status_r | sel_mask;
          SBF_OP_FLAG_CLEAR_GENERIC: status_nxt = status_r & ~sel_mask;
          SBF_OP_BIT_TO_TRANSFER_FLAG: status_nxt[SBF_FLAG_T] = wreg_r[cmd.sel];
          SBF_OP_TRANSFER_FLAG_TO_BIT: wreg_nxt[cmd.sel] = t_in;
          SBF_OP_SIGN_FLAG_SET: status_nxt[SBF_FLAG_S] = 1'b1;
          SBF_OP_SIGN_FLAG_CLEAR: status_nxt[SBF_FLAG_S] = 1'b0;
          SBF_OP_OVERFLOW_FLAG_SET: status_nxt[SBF_FLAG_V] = 1'b1;
          SBF_OP_OVERFLOW_FLAG_CLEAR: status_nxt[SBF_FLAG_V] = 1'b0;
          SBF_OP_HALF_CARRY_SET: status_nxt[SBF_FLAG_H] = 1'b1;
          SBF_OP_HALF_CARRY_CLEAR: status_nxt[SBF_FLAG_H] = 1'b0;
          SBF_OP_INTERRUPT_ENABLE_INSTR: status_nxt[SBF_FLAG_I] = 1'b1;
          SBF_OP_INTERRUPT_DISABLE_INSTR: status_nxt[SBF_FLAG_I] = 1'b0;
          default: ;
        endcase
      end
    end else if (wr_wreg && hreadyout) begin
      wreg_nxt = hwdata[7:0];
    end else if (wr_stat && hreadyout) begin
      status_nxt = hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wreg_r <= SBF_WREG_RST;
      status_r <= SBF_STATUS_RST;
    end else begin
      wreg_r <= wreg_nxt;
      status_r <= status_nxt;
    end
  end

  // ----------------------------------------
  // Multi-cycle sleep and watchdog pulse
  // ----------------------------------------
  wire go_sleep = go && (sbf_op_t'(cmd.op) == SBF_OP_SLEEP);
  wire go_wdr = go && (sbf_op_t'(cmd.op) == SBF_OP_WATCHDOG_RESTART_INSTR);
  localparam logic [1:0] SLEEP_EXTRA = 2'(SBF_CYC_SLEEP - SBF_CYC_SINGLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_cnt_r <= 2'd0;
      sleep_req_r <= 1'b0;
      wdr_r <= 1'b0;
    end else begin
      if (go_sleep) begin
        sleep_cnt_r <= SLEEP_EXTRA;
      end else if (sleeping) begin
        sleep_cnt_r <= sleep_cnt_r - 2'd1;
      end
      sleep_req_r <= sleeping && (sleep_cnt_r == 2'd1);
      wdr_r <= go_wdr;
    end
  end

  // ----------------------------------------
  // Read data and bus answer
  // ----------------------------------------
  wire [31:0] rd_mux = (addr_r == SBF_WREG_OFS) ? {24'h000000, wreg_r} :
                       (addr_r == SBF_STATUS_OFS) ? {24'h000000, status_r} :
                       (addr_r == SBF_STATE_OFS) ? {30'h0, sleep_cnt_r} :
                       32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (addr_ok && !ahb_req.hwrite && hreadyout) begin
      hrdata_r <= 32'h00000000;
    end
  end

  assign hrdata = rd_pend_r ? rd_mux : hrdata_r;
  assign hreadyout = !sleeping;
  assign hresp = 1'b0;
  assign sleep_req = sleep_req_r;
  assign watchdog_restart = wdr_r;
  assign busy = sleeping;

endmodule

/* test/sbf_exec_unit_assertions.sv */
// Concurrent checks on the execution unit's bus and event ports
`timescale 1ns/1ps
module sbf_exec_unit_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire sbf_pkg::sbf_ahb_req_t ahb_req,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Execution events
  input wire logic sleep_req,
  input wire logic watchdog_restart,
  input wire logic busy
);
  import sbf_pkg::*;
  // ----------------------------------------
  // Command data phase tracking
  // ----------------------------------------
  logic dp_cmd_r;
  logic dp_cmd_nxt;
  logic fire;
  logic sleep_fire;
  logic wdr_fire;
  assign dp_cmd_nxt = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hwrite
                      && ahb_req.haddr[7:0] == SBF_CMD_OFS;
  assign fire = dp_cmd_r && hreadyout;
  assign sleep_fire = fire && hwdata[4:0] == SBF_OP_SLEEP;
  assign wdr_fire = fire && hwdata[4:0] == SBF_OP_WATCHDOG_RESTART_INSTR;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dp_cmd_r <= 1'b0;
    else if (ahb_req.hready) dp_cmd_r <= dp_cmd_nxt;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_sleep_stall; sleep_fire |=> !hreadyout [*2] ##1 (hreadyout && sleep_req); endproperty
  a_sleep_stall: assert property (p_sleep_stall) else $error("sleep stall wrong");
  property p_sleep_busy; sleep_fire |=> busy [*2]; endproperty
  a_sleep_busy: assert property (p_sleep_busy) else $error("busy missing in sleep");
  property p_sleep_cause; sleep_req |-> $past(hreadyout) == 1'b0 && $past(hreadyout, 2) == 1'b0;
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep pulse early");
  property p_sleep_pulse; sleep_req |=> !sleep_req; endproperty
  a_sleep_pulse: assert property (p_sleep_pulse) else $error("sleep pulse long");
  property p_stall_cause; $fell(hreadyout) |-> $past(sleep_fire); endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall without sleep");
  property p_wdr; wdr_fire |=> watchdog_restart; endproperty
  a_wdr: assert property (p_wdr) else $error("restart pulse missing");
  property p_wdr_cause; watchdog_restart |-> $past(wdr_fire); endproperty
  a_wdr_cause: assert property (p_wdr_cause) else $error("restart pulse unasked");
  property p_single; fire && !sleep_fire |=> hreadyout && !busy; endproperty
  a_single: assert property (p_single) else $error("command stalled");
endmodule

bind sbf_exec_unit sbf_exec_unit_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
  .ahb_req(ahb_req), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .sleep_req(sleep_req), .watchdog_restart(watchdog_restart), .busy(busy));

/* test/sbf_exec_unit_test.sv */
// Self-checking bench for the shift, bit and flag execution unit
`timescale 1ns/1ps
module sbf_exec_unit_test;
  import sbf_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sleep_req, watchdog_restart, busy;
  logic [1:0] htrans;
  logic [7:0] haddr, rnd, w, s;
  logic [31:0] hwdata, hrdata, q;
  logic [2:0] sel;
  logic [4:0] op;
  logic [15:0] e;
  int failures, checks_done, cyc;
  sbf_ahb_req_t req;
  // Slave hreadyout closes the loop as the bus hready
  assign req = '{hsel: hsel, haddr: {24'h0, haddr}, htrans: htrans, hwrite: hwrite,
                 hsize: 3'h2, hready: hreadyout};
  sbf_exec_unit dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_req(sleep_req),
    .watchdog_restart(watchdog_restart), .busy(busy));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [15:0] model(input logic [4:0] o, input logic [2:0] b,
                                        input logic [7:0] x, input logic [7:0] f);
    logic [7:0] r;
    r = x;
    case (o)
      5'h01: {f[0], r} = {x, 1'b0};
      5'h02: {r, f[0]} = {1'b0, x};
      5'h03: {f[0], r} = {x, f[0]};
      5'h04: {r, f[0]} = {f[0], x};
      5'h05: {r, f[0]} = {x[7], x};
      5'h06: r = {x[3:0], x[7:4]};
      5'h07: f[b] = 1'b1;
      5'h08: f[b] = 1'b0;
      5'h09: f[6] = x[b];
      5'h0A: r[b] = f[6];
      5'h0B, 5'h0C: f[4] = o == 5'h0B;
      5'h0D, 5'h0E: f[3] = o == 5'h0D;
      5'h0F, 5'h10: f[5] = o == 5'h0F;
      5'h11, 5'h12: f[7] = o == 5'h11;
      default: ;
    endcase
    // Shift group recomputes zero, negative and overflow from the result
    if (o inside {[5'h01:5'h05]}) begin
      f[1] = r == 8'h00;
      f[2] = r[7];
      f[3] = r[7] ^ f[0];
    end
    return {r, f};
  endfunction
  task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Single transfer; waits on hready, the timeout cuts a hang
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    rnd = 8'h3E;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, SBF_WREG_OFS, 32'h0);
    check("wreg_rst", q, {24'h0, SBF_WREG_RST});
    xfer(1'b0, SBF_STATUS_OFS, 32'h0);
    check("status_rst", q, {24'h0, SBF_STATUS_RST});
    xfer(1'b1, 8'h10, 32'hFF);
    xfer(1'b0, 8'h10, 32'h0);
    check("unmapped", q, 32'h0);
    xfer(1'b1, SBF_STATE_OFS, 32'h5A);
    xfer(1'b0, SBF_STATE_OFS, 32'h0);
    check("state_ro", q, 32'h0);
    // First two rounds use edge values, the rest random; the last slot is an unknown opcode
    for (int i = 0; i < 132; i++) begin
      rnd = lfsr(rnd);
      w = i < 22 ? 8'h80 : i < 44 ? 8'h01 : rnd;
      rnd = lfsr(rnd);
      s = rnd;
      rnd = lfsr(rnd);
      sel = rnd[2:0];
      op = i % 22 == 21 ? 5'h1F : 5'(i % 22);
      xfer(1'b1, SBF_WREG_OFS, {24'h0, w});
      xfer(1'b1, SBF_STATUS_OFS, {24'h0, s});
      xfer(1'b1, SBF_CMD_OFS, {21'h0, sel, 3'h0, op});
      e = model(op, sel, w, s);
      xfer(1'b0, SBF_WREG_OFS, 32'h0);
      check("wreg", q, {24'h0, e[15:8]});
      xfer(1'b0, SBF_STATUS_OFS, 32'h0);
      check("status", q, {24'h0, e[7:0]});
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    wrap_up;
  end
endmodule
